// File: memcfg_pkg.sv
// Constants and types for the configurable memory block
package memcfg_pkg;
  localparam int TOTAL_BITS = 16384;
  localparam int MEM_WORD   = 32;
  localparam int MEM_DEPTH  = TOTAL_BITS / MEM_WORD;
  localparam int MEM_AW     = 9;
  localparam int ADDR_W     = 14;
  localparam int CNT_W      = 15;
  localparam int NETS       = 4;
  localparam int GRP_INPUTS = 68;

  localparam logic [2:0]        WSEL_MAX   = 3'h5;
  localparam logic [2:0]        WSEL_RESET = 3'h5;
  localparam logic [2:0]        SRC_LOCAL  = 3'h0;
  localparam logic [1:0]        EN_LOCAL   = 2'h0;
  localparam logic [1:0]        EN_NET1    = 2'h1;
  localparam logic [1:0]        EN_NET2    = 2'h2;
  localparam logic [CNT_W-1:0]  CAP_WORDS1 = 15'h4000;
  localparam logic [31:0]       DOUT_RESET = 32'h0;
  localparam logic [ADDR_W-1:0] PTR_RESET  = 14'h0;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 15'h0;

  typedef enum logic [5:0] {
    MODE_WIDE = 6'h01,
    MODE_TDP  = 6'h02,
    MODE_PDP  = 6'h04,
    MODE_SRAM = 6'h08,
    MODE_FIFO = 6'h10,
    MODE_CAM  = 6'h20
  } mode_t;

  localparam mode_t MODE_RESET = MODE_SRAM;

  typedef struct packed {
    logic [2:0] sel;
    logic       inv;
  } clk_src_t;

  typedef struct packed {
    logic [1:0] sel;
    logic       inv;
  } en_src_t;

  typedef struct packed {
    logic [CNT_W-1:0] full;
    logic [CNT_W-1:0] afull;
    logic [CNT_W-1:0] aempty;
  } fifo_thr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic              cs;
    logic              wr;
  } sram_req_t;
endpackage

// File: mem_array.sv
// Storage array with masked synchronous write and combinational read
`timescale 1ns/1ns
`default_nettype none
module mem_array
  import memcfg_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int WIDTH = MEM_WORD,
  parameter int AW    = MEM_AW
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [WIDTH-1:0] wmask,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  assign rdata = mem[raddr];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
  end
endmodule
`default_nettype wire

// File: mem_fifo_block.sv
// Configurable memory block working as single-port SRAM or FIFO
`timescale 1ns/1ns
`default_nettype none
module mem_fifo_block
  import memcfg_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  input  wire logic       GLOBAL_RST,
  input  wire logic       LOCAL_RST,
  input  wire logic       LOCAL_RST_INV,
  input  wire logic [3:0] GLOBAL_CLOCK_NETS,
  input  wire mode_t      MODE,
  input  wire logic [2:0] WIDTH_SEL,
  input  wire clk_src_t   SRAM_CLK_SRC,
  input  wire en_src_t    SRAM_EN_SRC,
  input  wire clk_src_t   PUSH_CLK_SRC,
  input  wire en_src_t    PUSH_EN_SRC,
  input  wire clk_src_t   POP_CLK_SRC,
  input  wire en_src_t    POP_EN_SRC,
  input  wire logic       SYNC_READ,
  input  wire logic       SHOW_AHEAD,
  input  wire fifo_thr_t  THRESHOLDS,
  input  wire sram_req_t  SRAM_REQ,
  input  wire logic       CLOCK_GATE_INPUT,
  input  wire logic       PUSH_ENABLE,
  input  wire logic [31:0] PUSH_DATA,
  input  wire logic       POP_ENABLE,
  input  wire logic       READ_PTR_RESET,
  output logic     [31:0] DOUT,
  output logic            FULL,
  output logic            ALMOST_FULL,
  output logic            EMPTY,
  output logic            ALMOST_EMPTY
);
  // Word index of an element at the selected width
  function automatic logic [MEM_AW-1:0] word_idx(input logic [ADDR_W-1:0] a,
                                                 input logic [2:0]        w);
    logic [ADDR_W-1:0] s;
    s = a >> (WSEL_MAX - w);
    word_idx = s[MEM_AW-1:0];
  endfunction

  // Bit offset of an element inside its word
  function automatic logic [4:0] bit_off(input logic [ADDR_W-1:0] a,
                                         input logic [2:0]        w);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] o;
    m = (14'h1 << (WSEL_MAX - w)) - 14'h1;
    o = (a & m) << w;
    bit_off = o[4:0];
  endfunction

  // Low-bit mask one element wide
  function automatic logic [31:0] lane_mask(input logic [2:0] w);
    logic [32:0] t;
    t = (33'h1 << (6'h1 << w)) - 33'h1;
    lane_mask = t[31:0];
  endfunction

  // Tick from the block clock or an edge of a global net
  function automatic logic pick_tick(input clk_src_t s,
                                     input logic [3:0] rise,
                                     input logic [3:0] fall);
    logic [1:0] n;
    n = 2'(s.sel - 3'h1);
    if (s.sel == SRC_LOCAL) begin
      pick_tick = 1'b1;
    end else if (s.sel > 3'h4) begin
      pick_tick = 1'b0;
    end else begin
      pick_tick = s.inv ? fall[n] : rise[n];
    end
  endfunction

  // Enable from the local pin or net 1 or 2
  function automatic logic pick_en(input en_src_t s,
                                   input logic local_en,
                                   input logic [3:0] lvl);
    logic e;
    case (s.sel)
      EN_LOCAL: e = local_en;
      EN_NET1:  e = lvl[1];
      EN_NET2:  e = lvl[2];
      default:  e = 1'b0;
    endcase
    pick_en = e ^ s.inv;
  endfunction

  // Combined asynchronous reset, RST_B low OR global OR local
  wire logic arst_b = RST_B & ~GLOBAL_RST & ~(LOCAL_RST ^ LOCAL_RST_INV);

  // Global nets synchronised, then edge detected
  logic [3:0] net_meta_reg;
  logic [3:0] net_sync_reg;
  logic [3:0] net_prev_reg;
  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      net_meta_reg <= 4'h0;
      net_sync_reg <= 4'h0;
      net_prev_reg <= 4'h0;
    end else if (CE) begin
      net_meta_reg <= GLOBAL_CLOCK_NETS;
      net_sync_reg <= net_meta_reg;
      net_prev_reg <= net_sync_reg;
    end
  end
  wire logic [3:0] net_rise = net_sync_reg & ~net_prev_reg;
  wire logic [3:0] net_fall = ~net_sync_reg & net_prev_reg;

  // Mode and width held in registers
  mode_t      mode_reg;
  logic [2:0] wsel_reg;
  wire logic [2:0] wsel_next = (WIDTH_SEL > WSEL_MAX) ? WSEL_MAX : WIDTH_SEL;
  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      mode_reg <= MODE_RESET;
      wsel_reg <= WSEL_RESET;
    end else if (CE) begin
      mode_reg <= MODE;
      wsel_reg <= wsel_next;
    end
  end
  wire logic sram_mode = (mode_reg == MODE_SRAM);
  wire logic fifo_mode = (mode_reg == MODE_FIFO);
  wire logic [31:0] lmask = lane_mask(wsel_reg);
  wire logic [CNT_W-1:0] cap = CAP_WORDS1 >> wsel_reg;

  // SRAM side
  wire logic sram_tick = pick_tick(SRAM_CLK_SRC, net_rise, net_fall);
  wire logic sram_en = pick_en(SRAM_EN_SRC, CLOCK_GATE_INPUT, net_sync_reg);
  wire logic sram_go = CE & sram_mode & sram_tick & sram_en;
  wire logic sram_we = sram_go & SRAM_REQ.cs & SRAM_REQ.wr;
  sram_req_t req_reg;
  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      req_reg <= '0;
    end else if (sram_go) begin
      req_reg <= SRAM_REQ;
    end
  end

  // FIFO side
  logic [ADDR_W-1:0] wptr_reg;
  logic [ADDR_W-1:0] rptr_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [ADDR_W-1:0] wptr_next;
  logic [ADDR_W-1:0] rptr_next;
  logic [CNT_W-1:0]  count_next;

  wire logic w_tick = CE & fifo_mode & pick_tick(PUSH_CLK_SRC, net_rise, net_fall);
  wire logic w_en = pick_en(PUSH_EN_SRC, PUSH_ENABLE, net_sync_reg);
  wire logic r_tick = CE & fifo_mode & pick_tick(POP_CLK_SRC, net_rise, net_fall);
  wire logic r_en = pick_en(POP_EN_SRC, POP_ENABLE, net_sync_reg);
  wire logic [CNT_W-1:0] full_lim = (THRESHOLDS.full < cap) ? THRESHOLDS.full : cap;
  wire logic push_ok = w_tick & w_en & (count_reg < full_lim);
  wire logic pop_ok = r_tick & r_en & (count_reg != CNT_RESET) & ~READ_PTR_RESET;
  wire logic rd_rewind = r_tick & READ_PTR_RESET;
  wire logic [ADDR_W-1:0] wptr_inc = wptr_reg + 14'h1;
  wire logic [ADDR_W-1:0] rptr_inc = rptr_reg + 14'h1;
  wire logic wptr_wrap = ({1'b0, wptr_inc} == cap);
  wire logic rptr_wrap = ({1'b0, rptr_inc} == cap);

  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (push_ok) begin
      wptr_next = wptr_wrap ? PTR_RESET : wptr_inc;
    end
    if (rd_rewind) begin
      rptr_next = PTR_RESET;
      count_next = {1'b0, wptr_next};
    end else begin
      if (pop_ok) begin
        rptr_next = rptr_wrap ? PTR_RESET : rptr_inc;
      end
      count_next = count_reg + {14'h0, push_ok} - {14'h0, pop_ok};
    end
  end

  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      wptr_reg <= PTR_RESET;
      rptr_reg <= PTR_RESET;
      count_reg <= CNT_RESET;
    end else if (CE) begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end

  // Flags registered on their own side
  wire logic wflag_go = w_tick & w_en;
  wire logic rflag_go = r_tick & r_en;
  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      FULL <= 1'b0;
      ALMOST_FULL <= 1'b0;
      EMPTY <= 1'b1;
      ALMOST_EMPTY <= 1'b1;
    end else begin
      if (wflag_go) begin
        FULL <= (count_next >= full_lim);
        ALMOST_FULL <= (count_next >= THRESHOLDS.afull);
      end
      if (rflag_go) begin
        EMPTY <= (count_next == CNT_RESET);
        ALMOST_EMPTY <= (count_next <= THRESHOLDS.aempty);
      end
    end
  end

  // Array port selection
  wire logic [ADDR_W-1:0] fifo_raddr = SHOW_AHEAD ? rptr_next : rptr_reg;
  wire logic [ADDR_W-1:0] sram_raddr = SYNC_READ ? req_reg.addr : SRAM_REQ.addr;
  wire logic [ADDR_W-1:0] rd_addr = sram_mode ? sram_raddr : fifo_raddr;
  wire logic [ADDR_W-1:0] wr_addr = sram_mode ? SRAM_REQ.addr : wptr_reg;
  wire logic [31:0] wr_src = sram_mode ? SRAM_REQ.data : PUSH_DATA;
  wire logic [4:0] wr_off = bit_off(wr_addr, wsel_reg);
  wire logic [4:0] rd_off = bit_off(rd_addr, wsel_reg);
  wire logic arr_we = sram_we | push_ok;
  wire logic [31:0] arr_wdata = (wr_src & lmask) << wr_off;
  wire logic [31:0] arr_wmask = lmask << wr_off;
  wire logic [31:0] arr_rdata;
  wire logic [31:0] rd_elem = (arr_rdata >> rd_off) & lmask;

  mem_array #(
    .DEPTH (MEM_DEPTH),
    .WIDTH (MEM_WORD),
    .AW    (MEM_AW)
  ) u_array (
    .clk   (CLK),
    .we    (arr_we),
    .waddr (word_idx(wr_addr, wsel_reg)),
    .wdata (arr_wdata),
    .wmask (arr_wmask),
    .raddr (word_idx(rd_addr, wsel_reg)),
    .rdata (arr_rdata)
  );

  // Read data register
  wire logic sram_rd_sync = sram_go & SYNC_READ & req_reg.cs & ~req_reg.wr;
  wire logic sram_rd_async = sram_go & ~SYNC_READ & SRAM_REQ.cs & ~SRAM_REQ.wr;
  wire logic fifo_rd = SHOW_AHEAD ? r_tick : pop_ok;
  wire logic dout_load = sram_rd_sync | sram_rd_async | fifo_rd;
  always_ff @(posedge CLK or negedge arst_b) begin
    if (!arst_b) begin
      DOUT <= DOUT_RESET;
    end else if (dout_load) begin
      DOUT <= rd_elem;
    end
  end
endmodule
`default_nettype wire

// File: mem_fifo_block_sva.sv
// Port checker for the memory block
`timescale 1ns/1ns
`default_nettype none
module mem_fifo_block_chk
  import memcfg_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CE,
  input wire logic        GLOBAL_RST,
  input wire logic        LOCAL_RST,
  input wire logic        LOCAL_RST_INV,
  input wire logic        PUSH_ENABLE,
  input wire logic        POP_ENABLE,
  input wire logic        READ_PTR_RESET,
  input wire logic [31:0] DOUT,
  input wire logic        FULL,
  input wire logic        ALMOST_FULL,
  input wire logic        EMPTY,
  input wire logic        ALMOST_EMPTY
);
  wire logic eff_rst;
  assign eff_rst = !RST_B || GLOBAL_RST || (LOCAL_RST ^ LOCAL_RST_INV);
  logic fed_reg;
  logic drained_reg;
  // Data may sit behind a stale flag once either side has moved
  always_ff @(posedge CLK) begin
    if (eff_rst) begin
      fed_reg <= 1'b0;
      drained_reg <= 1'b0;
    end else begin
      if (PUSH_ENABLE || READ_PTR_RESET) begin
        fed_reg <= 1'b1;
      end else if (!EMPTY) begin
        fed_reg <= 1'b0;
      end
      if (POP_ENABLE || READ_PTR_RESET) begin
        drained_reg <= 1'b1;
      end else if (!FULL) begin
        drained_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (eff_rst);
  chk_reset_flags: assert property ($rose(RST_B)
    |-> EMPTY && ALMOST_EMPTY && !FULL && !ALMOST_FULL && DOUT == 32'h0)
    else $error("flags not at reset values");
  chk_empty_ae: assert property (EMPTY |-> ALMOST_EMPTY)
    else $error("empty without almost empty");
  chk_full_af: assert property (FULL |-> ALMOST_FULL)
    else $error("full without almost full");
  chk_ce_freeze: assert property (!CE
    |=> $stable(DOUT) && $stable(FULL) && $stable(EMPTY))
    else $error("state moved with enable low");
  chk_empty_hold: assert property (EMPTY && !fed_reg && !PUSH_ENABLE && !READ_PTR_RESET
    |=> EMPTY) else $error("empty left without data");
  chk_full_hold: assert property (FULL && !drained_reg && !POP_ENABLE && !READ_PTR_RESET
    |=> FULL) else $error("full left without pop");
  chk_af_rise: assert property ($rose(ALMOST_FULL)
    |-> $past(PUSH_ENABLE) && $past(CE)) else $error("almost full rose off push");
  chk_empty_fall: assert property ($fell(EMPTY)
    |-> $past(POP_ENABLE) && $past(CE)) else $error("empty fell off pop");
  cover property ($rose(FULL));
  cover property ($fell(EMPTY));
  cover property (READ_PTR_RESET && POP_ENABLE);
endmodule
`default_nettype wire

// File: fabric_user.sv
// Fabric user logic gating push and pop on the flags
`timescale 1ns/1ns
`default_nettype none
module fabric_user (
  input  wire logic full,
  input  wire logic empty,
  input  wire logic want_push,
  input  wire logic want_pop,
  input  wire logic rude,
  output logic      push_en,
  output logic      pop_en
);
  // Holds off on full and empty unless told to misbehave
  assign push_en = want_push & (rude | ~full);
  assign pop_en  = want_pop & (rude | ~empty);
endmodule
`default_nettype wire

// File: tb.sv
// Testbench for the memory block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module tb;
  import memcfg_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, grst = 1'b0, lrst_inv = 1'b0;
  logic        sync_rd = 1'b0, cgi = 1'b1, wp = 1'b0, wo = 1'b0, rude = 1'b0, rptr = 1'b0;
  mode_t       mode = MODE_FIFO;
  clk_src_t    csrc = '0;
  en_src_t     esrc = '0;
  fifo_thr_t   thr = '{full: 15'h4, afull: 15'h3, aempty: 15'h1};
  sram_req_t   req = '0;
  logic [31:0] pdata = 32'h0, dout;
  logic        sa = 1'b0;
  logic [2:0]  wsel = 3'h5;
  logic [3:0]  nets = 4'h0;
  logic        full, afull, empty, aempty, push_en, pop_en;
  int          err_total = 0, checked = 0, cyc = 0;
  // Row layout: ctrl{push,pop,rude,rewind}, data, expected dout, flags{F,AF,E,AE}
  logic [23:0] rows [16] = '{24'h8a1003, 24'h8a2003, 24'h8a3007, 24'h8a400f,
    24'h8a500f, 24'h600a1c, 24'h400a2c, 24'haa5a24, 24'h400a34, 24'h400a45,
    24'h400a57, 24'h600a57, 24'h700a54, 24'h400a14, 24'haa6a1c, 24'h400a2c};

  mem_fifo_block i_dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .GLOBAL_RST(grst),
    .LOCAL_RST(1'b0), .LOCAL_RST_INV(lrst_inv), .GLOBAL_CLOCK_NETS(nets),
    .MODE(mode), .WIDTH_SEL(wsel), .SRAM_CLK_SRC(csrc), .SRAM_EN_SRC(esrc),
    .PUSH_CLK_SRC(csrc), .PUSH_EN_SRC(esrc), .POP_CLK_SRC(csrc), .POP_EN_SRC(esrc),
    .SYNC_READ(sync_rd), .SHOW_AHEAD(sa), .THRESHOLDS(thr), .SRAM_REQ(req),
    .CLOCK_GATE_INPUT(cgi), .PUSH_ENABLE(push_en), .PUSH_DATA(pdata),
    .POP_ENABLE(pop_en), .READ_PTR_RESET(rptr), .DOUT(dout), .FULL(full),
    .ALMOST_FULL(afull), .EMPTY(empty), .ALMOST_EMPTY(aempty));
  fabric_user i_user (.full(full), .empty(empty), .want_push(wp), .want_pop(wo),
    .rude(rude), .push_en(push_en), .pop_en(pop_en));

  always #25 clk = ~clk;

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic step(input logic [3:0] c, input logic [7:0] d);
    {wp, wo, rude, rptr} = c;
    pdata = {24'h0, d};
    @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    step(4'h0, 8'h0);
    step(4'h0, 8'h0);
    foreach (rows[i]) begin
      step(rows[i][23:20], rows[i][19:12]);
      `CHK("dout", {24'h0, rows[i][11:4]}, dout)
      `CHK("flags", rows[i][3:0], {full, afull, empty, aempty})
    end
    grst = 1'b1;
    #1;
    `CHK("grst flags", 4'h3, {full, afull, empty, aempty})
    `CHK("grst dout", 32'h0, dout)
    @(negedge clk);
    grst = 1'b0;
    step(4'h0, 8'h0);
    step(4'h8, 8'hc3);
    step(4'h6, 8'h0);
    `CHK("pop after grst", 32'hc3, dout)
    lrst_inv = 1'b1;
    #1;
    `CHK("local rst dout", 32'h0, dout)
    @(negedge clk);
    lrst_inv = 1'b0;
    mode = MODE_SRAM;
    step(4'h0, 8'h0);
    step(4'h0, 8'h0);
    req = '{addr: 14'h5, data: 32'h1234abcd, cs: 1'b1, wr: 1'b1};
    step(4'h0, 8'h0);
    req = '{addr: 14'h6, data: 32'h5a5a0f0f, cs: 1'b1, wr: 1'b1};
    step(4'h0, 8'h0);
    req = '{addr: 14'h5, data: 32'h0, cs: 1'b1, wr: 1'b0};
    step(4'h0, 8'h0);
    `CHK("async rd", 32'h1234abcd, dout)
    sync_rd = 1'b1;
    req.addr = 14'h6;
    step(4'h0, 8'h0);
    step(4'h0, 8'h0);
    `CHK("sync rd", 32'h5a5a0f0f, dout)
    sync_rd = 1'b0;
    ce = 1'b0;
    req.addr = 14'h5;
    step(4'h0, 8'h0);
    `CHK("ce hold", 32'h5a5a0f0f, dout)
    ce = 1'b1;
    step(4'h0, 8'h0);
    `CHK("ce run", 32'h1234abcd, dout)
    wsel = 3'h3;
    req = '0;
    step(4'h0, 8'h0);
    req = '{addr: 14'h6, data: 32'hffffff77, cs: 1'b1, wr: 1'b1};
    step(4'h0, 8'h0);
    req = '{addr: 14'h7, data: 32'h88, cs: 1'b1, wr: 1'b1};
    step(4'h0, 8'h0);
    req = '{addr: 14'h6, data: 32'h0, cs: 1'b1, wr: 1'b0};
    step(4'h0, 8'h0);
    `CHK("narrow rd", 32'h77, dout)
    csrc = '{sel: 3'h1, inv: 1'b0};
    req.addr = 14'h7;
    nets = 4'h1;
    step(4'h0, 8'h0);
    step(4'h0, 8'h0);
    `CHK("net wait", 32'h77, dout)
    step(4'h0, 8'h0);
    `CHK("net tick", 32'h88, dout)
    csrc = '0;
    nets = 4'h0;
    wsel = 3'h5;
    mode = MODE_FIFO;
    sa = 1'b1;
    req = '0;
    grst = 1'b1;
    @(negedge clk);
    grst = 1'b0;
    step(4'h0, 8'h0);
    step(4'h0, 8'h0);
    step(4'h8, 8'h5c);
    step(4'h8, 8'h6d);
    `CHK("ahead first", 32'h5c, dout)
    step(4'h6, 8'h0);
    `CHK("ahead next", 32'h6d, dout)
    tally_and_finish;
  end
endmodule

bind mem_fifo_block mem_fifo_block_chk i_chk (.CLK(CLK), .RST_B(RST_B), .CE(CE),
  .GLOBAL_RST(GLOBAL_RST), .LOCAL_RST(LOCAL_RST), .LOCAL_RST_INV(LOCAL_RST_INV),
  .PUSH_ENABLE(PUSH_ENABLE), .POP_ENABLE(POP_ENABLE), .READ_PTR_RESET(READ_PTR_RESET),
  .DOUT(DOUT), .FULL(FULL), .ALMOST_FULL(ALMOST_FULL), .EMPTY(EMPTY),
  .ALMOST_EMPTY(ALMOST_EMPTY));
`default_nettype wire
